// [core/cpu_interrupt_sequencer.sv]
// register set, flags and interrupt sequencer of the 8-bit core
`timescale 1ns/100ps

module cpu_interrupt_sequencer (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// execution unit
	input cpu_seq_pkg::exec_t exec,
	output logic exec_stall,
	// interrupt sources
	input wire logic ext_irq_n,
	input wire logic [7:0] portb_pins_n,
	input wire logic [7:0] portb_irq_en,
	input cpu_seq_pkg::irq_src_t src_en,
	input cpu_seq_pkg::irq_src_t src_flag,
	// vector fetch and stack memory
	output logic [12:0] vec_addr,
	output logic vec_rd,
	input wire logic [12:0] vec_data,
	output cpu_seq_pkg::stack_bus_t stack_bus,
	input wire logic [7:0] stack_rdata,
	// architectural state and clock controls
	output logic [7:0] accum,
	output logic [7:0] index_reg,
	output logic [12:0] program_counter,
	output logic [5:0] stack_pointer,
	output logic [4:0] condition_flags,
	output logic osc_off,
	output logic cpu_clk_off
);
	import cpu_seq_pkg::*;

	typedef enum logic [6:0] {
		st_run = 7'h01,
		st_push = 7'h02,
		st_vec = 7'h04,
		st_pull = 7'h08,
		st_stop = 7'h10,
		st_wait = 7'h20,
		st_rstv = 7'h40
	} state_t;

	state_t state_q, state_d;
	logic [7:0] a_q, x_q;
	logic [12:0] pc_q;
	logic [5:0] sp_q;
	logic [4:0] ccr_q;
	logic [2:0] cnt_q;
	logic [12:0] tvec_q;
	logic irq_prev_q, irq_lat_q, irq_sync1_q, irq_sync2_q;
	logic ext_level, ext_req, tmr_req, asy_req, syn_req, any_req, take_irq;
	logic [12:0] sel_vec;
	logic [8:0] sum;
	logic [4:0] low_sum;
	logic [7:0] res;
	logic end_instr, push_step, pull_step;

	//------------------------------------------------------------
	// external request capture
	//------------------------------------------------------------
	assign ext_level = ext_irq_n & ~|(~portb_pins_n & portb_irq_en);

	// edge latch cleared when the vector is taken, so one later pulse can wait
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_prev_q <= 1'b1;
			irq_lat_q <= 1'b0;
		end else begin
			irq_prev_q <= ext_level;
			if (irq_prev_q & ~ext_level) begin
				irq_lat_q <= 1'b1;
			end else if (state_q == st_vec && tvec_q == ext_vec) begin
				irq_lat_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_sync1_q <= 1'b0;
			irq_sync2_q <= 1'b0;
		end else begin
			irq_sync1_q <= irq_lat_q;
			irq_sync2_q <= irq_sync1_q & irq_lat_q;
		end
	end

	//------------------------------------------------------------
	// arbitration
	//------------------------------------------------------------
	assign ext_req = irq_sync2_q & src_en.ext;
	assign tmr_req = |(src_en.tmr & src_flag.tmr);
	assign asy_req = |(src_en.async_ser & src_flag.async_ser);
	assign syn_req = |(src_en.sync_ser & src_flag.sync_ser);
	assign any_req = ext_req | tmr_req | asy_req | syn_req;
	assign end_instr = exec.done && state_q == st_run;
	// pending requests go before a trap completing now
	assign take_irq = end_instr && !ccr_q[ccr_i] && any_req;

	always_comb begin
		if (ext_req) begin
			sel_vec = ext_vec;
		end else if (tmr_req) begin
			sel_vec = tmr_vec;
		end else if (asy_req) begin
			sel_vec = async_vec;
		end else begin
			sel_vec = sync_vec;
		end
	end

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	assign push_step = state_q == st_push;
	assign pull_step = state_q == st_pull;

	always_comb begin
		state_d = state_q;
		case (state_q)
			st_run: begin
				if (take_irq || (end_instr && exec.cmd == cmd_swi)) begin
					state_d = st_push;
				end else if (end_instr && exec.cmd == cmd_rti) begin
					state_d = st_pull;
				end else if (end_instr && exec.cmd == cmd_stop) begin
					state_d = st_stop;
				end else if (end_instr && exec.cmd == cmd_wait) begin
					state_d = st_wait;
				end
			end
			st_push: if (cnt_q == 3'd4) state_d = st_vec;
			st_pull: if (cnt_q == 3'd4) state_d = st_run;
			st_vec, st_rstv: state_d = st_run;
			st_stop: if (ext_req) state_d = st_push;
			st_wait: if (any_req) state_d = st_push;
			default: state_d = st_rstv;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_q <= st_rstv;
			cnt_q <= 3'd0;
			tvec_q <= pc_rst_vec;
		end else begin
			state_q <= state_d;
			cnt_q <= (push_step || pull_step) ? cnt_q + 3'd1 : 3'd0;
			if (state_q == st_run && state_d == st_push) begin
				tvec_q <= take_irq ? sel_vec : swi_vec;
			end else if ((state_q == st_stop || state_q == st_wait) && state_d == st_push) begin
				tvec_q <= sel_vec;
			end
		end
	end

	//------------------------------------------------------------
	// stack and memory ports
	//------------------------------------------------------------
	always_comb begin
		stack_bus.we = push_step;
		stack_bus.re = pull_step;
		stack_bus.addr = {stack_page[1:0], pull_step ? sp_q + 6'd1 : sp_q};
		case (cnt_q)
			3'd0: stack_bus.wdata = pc_q[7:0];
			3'd1: stack_bus.wdata = {3'd0, pc_q[12:8]};
			3'd2: stack_bus.wdata = x_q;
			3'd3: stack_bus.wdata = a_q;
			default: stack_bus.wdata = {3'h7, ccr_q};
		endcase
	end

	assign vec_rd = state_q == st_vec || state_q == st_rstv;
	assign vec_addr = tvec_q;
	assign exec_stall = state_q != st_run;
	assign osc_off = state_q == st_stop;
	assign cpu_clk_off = state_q == st_wait || state_q == st_stop;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sp_q <= sp_top;
		end else if (push_step || (end_instr && exec.cmd == cmd_push)) begin
			sp_q <= sp_q - 6'd1;
		end else if (pull_step || (end_instr && exec.cmd == cmd_pull)) begin
			sp_q <= sp_q + 6'd1;
		end else if (end_instr && exec.cmd == cmd_rsp) begin
			sp_q <= sp_top;
		end
	end

	//------------------------------------------------------------
	// program counter
	//------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			pc_q <= 13'h0000;
		end else if (vec_rd) begin
			pc_q <= vec_data;
		end else if (pull_step && cnt_q == 3'd3) begin
			pc_q <= {stack_rdata[4:0], pc_q[7:0]};
		end else if (pull_step && cnt_q == 3'd4) begin
			pc_q <= {pc_q[12:8], stack_rdata};
		end else if (end_instr && !take_irq) begin
			pc_q <= exec.next_pc;
		end else if (end_instr && take_irq && exec.cmd != cmd_swi) begin
			pc_q <= exec.next_pc;
		end
	end

	//------------------------------------------------------------
	// ALU result and flags
	//------------------------------------------------------------
	always_comb begin
		low_sum = {1'b0, exec.a_opnd[3:0]} + {1'b0, exec.b_opnd[3:0]}
			+ {4'd0, exec.op == op_adc && ccr_q[ccr_c]};
		case (exec.op)
			op_add, op_adc: sum = {1'b0, exec.a_opnd} + {1'b0, exec.b_opnd}
				+ {8'd0, exec.op == op_adc && ccr_q[ccr_c]};
			op_sub: sum = {1'b0, exec.a_opnd} - {1'b0, exec.b_opnd};
			op_shift: sum = {exec.bit_val, exec.a_opnd};
			default: sum = {1'b0, exec.b_opnd};
		endcase
		res = sum[7:0];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			a_q <= 8'h00;
			x_q <= 8'h00;
		end else if (pull_step && cnt_q == 3'd1) begin
			a_q <= stack_rdata;
		end else if (pull_step && cnt_q == 3'd2) begin
			x_q <= stack_rdata;
		end else if (end_instr && exec.op == op_load_x) begin
			x_q <= res;
		end else if (end_instr && exec.op inside {op_load_a, op_add, op_adc, op_sub,
			op_logic, op_shift}) begin
			a_q <= res;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ccr_q <= ccr_rst;
		end else if (pull_step && cnt_q == 3'd0) begin
			ccr_q <= stack_rdata[4:0];
		end else if (state_q == st_vec) begin
			ccr_q[ccr_i] <= 1'b1;
		end else if ((state_q == st_stop || state_q == st_wait) && state_d == st_push) begin
			ccr_q[ccr_i] <= 1'b0;
		end else if (end_instr) begin
			case (exec.op)
				op_add, op_adc: begin
					ccr_q[ccr_h] <= low_sum[4];
					ccr_q[ccr_c] <= sum[8];
					ccr_q[ccr_n] <= res[7];
					ccr_q[ccr_z] <= res == 8'h00;
				end
				op_sub, op_shift: begin
					ccr_q[ccr_c] <= sum[8];
					ccr_q[ccr_n] <= res[7];
					ccr_q[ccr_z] <= res == 8'h00;
				end
				op_load_a, op_load_x, op_logic: begin
					ccr_q[ccr_n] <= res[7];
					ccr_q[ccr_z] <= res == 8'h00;
				end
				op_btst, op_setc: ccr_q[ccr_c] <= exec.bit_val;
				op_cli: ccr_q[ccr_i] <= 1'b0;
				op_sei: ccr_q[ccr_i] <= 1'b1;
				default: ccr_q <= ccr_q;
			endcase
		end
	end

	assign accum = a_q;
	assign index_reg = x_q;
	assign program_counter = pc_q;
	assign stack_pointer = sp_q;
	assign condition_flags = ccr_q;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	sequence s_entry;
		state_q == st_push [*5] ##1 state_q == st_vec;
	endsequence

	a_push_five: assert property (@(posedge mclk) disable iff (rst)
		$rose(state_q == st_push) |-> s_entry) else $error("entry not five pushes");
	a_mask_set: assert property (@(posedge mclk) disable iff (rst)
		state_q == st_vec |=> ccr_q[ccr_i]) else $error("mask not set");
	a_pc_first: assert property (@(posedge mclk) disable iff (rst)
		$rose(state_q == st_push) |-> stack_bus.wdata == pc_q[7:0])
		else $error("pc low not first");
	a_no_masked: assert property (@(posedge mclk) disable iff (rst)
		ccr_q[ccr_i] |-> !take_irq) else $error("masked interrupt taken");
	a_ext_first: assert property (@(posedge mclk) disable iff (rst)
		take_irq && ext_req |=> tvec_q == ext_vec) else $error("priority");
	a_sp_dec: assert property (@(posedge mclk) disable iff (rst)
		push_step |=> sp_q == $past(sp_q) - 6'd1) else $error("sp push");
	a_stack_page: assert property (@(posedge mclk) disable iff (rst)
		stack_bus.we |-> stack_bus.addr[7:6] == 2'b11) else $error("stack page");
	a_swi_vec: assert property (@(posedge mclk) disable iff (rst)
		end_instr && exec.cmd == cmd_swi && !take_irq |=> tvec_q == swi_vec)
		else $error("trap vector");
	a_rti_len: assert property (@(posedge mclk) disable iff (rst)
		$rose(pull_step) |-> pull_step [*5] ##1 state_q == st_run)
		else $error("return length");
endmodule

// [core/cpu_seq_pkg.sv]
// shared constants and types for the core register set and interrupt sequencer
package cpu_seq_pkg;
	localparam logic [12:0] pc_rst_vec = 13'h1ffe;
	localparam logic [12:0] swi_vec = 13'h1ffc;
	localparam logic [12:0] ext_vec = 13'h1ffa;
	localparam logic [12:0] tmr_vec = 13'h1ff8;
	localparam logic [12:0] async_vec = 13'h1ff6;
	localparam logic [12:0] sync_vec = 13'h1ff4;
	localparam logic [5:0] sp_top = 6'h3f;
	localparam logic [6:0] stack_page = 7'h03;
	localparam logic [4:0] ccr_rst = 5'h08;
	localparam int ccr_h = 4;
	localparam int ccr_i = 3;
	localparam int ccr_n = 2;
	localparam int ccr_z = 1;
	localparam int ccr_c = 0;

	typedef enum logic [3:0] {
		op_none = 4'h0,
		op_load_a = 4'h1,
		op_load_x = 4'h2,
		op_add = 4'h3,
		op_adc = 4'h4,
		op_sub = 4'h5,
		op_logic = 4'h6,
		op_shift = 4'h7,
		op_btst = 4'h8,
		op_setc = 4'h9,
		op_cli = 4'ha,
		op_sei = 4'hb
	} alu_op_t;

	typedef enum logic [3:0] {
		cmd_none = 4'h0,
		cmd_swi = 4'h1,
		cmd_rti = 4'h2,
		cmd_rsp = 4'h3,
		cmd_stop = 4'h4,
		cmd_wait = 4'h5,
		cmd_jump = 4'h6,
		cmd_push = 4'h7,
		cmd_pull = 4'h8
	} seq_cmd_t;

	// one instruction completion reported by the execution unit
	typedef struct packed {
		logic done;
		seq_cmd_t cmd;
		alu_op_t op;
		logic [7:0] a_opnd;
		logic [7:0] b_opnd;
		logic [12:0] next_pc;
		logic bit_val;
	} exec_t;

	// stack memory port, byte wide
	typedef struct packed {
		logic we;
		logic re;
		logic [7:0] addr;
		logic [7:0] wdata;
	} stack_bus_t;

	typedef struct packed {
		logic ext;
		logic [2:0] tmr;
		logic [4:0] async_ser;
		logic [1:0] sync_ser;
	} irq_src_t;
endpackage

// [verif/cpu_interrupt_sequencer_bench.sv]
// self-checking bench for the register set and interrupt sequencer
`timescale 1ns/100ps
module cpu_interrupt_sequencer_bench;
	import cpu_seq_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	exec_t exec;
	irq_src_t src_en, src_flag;
	stack_bus_t stack_bus;
	logic exec_stall, ext_irq_n, vec_rd, osc_off, cpu_clk_off;
	logic [7:0] portb_pins_n, portb_irq_en, stack_rdata, accum, index_reg;
	logic [12:0] vec_addr, vec_data, program_counter, np, snp;
	logic [5:0] stack_pointer, esp, ssp;
	logic [4:0] condition_flags, eccr, sccr;
	logic [7:0] ea, ex, sa, sx, a, b;
	logic [7:0] ca [3] = '{8'h0f, 8'hff, 8'h00};
	alu_op_t o;
	int bad_count = 0;
	int checks = 0;
	always #12.5 mclk = ~mclk;
	cpu_interrupt_sequencer dut(.mclk, .rst, .exec, .exec_stall, .ext_irq_n, .portb_pins_n,
		.portb_irq_en, .src_en, .src_flag, .vec_addr, .vec_rd, .vec_data, .stack_bus,
		.stack_rdata, .accum, .index_reg, .program_counter, .stack_pointer,
		.condition_flags, .osc_off, .cpu_clk_off);
	mem_model mdl(.mclk, .vec_addr, .vec_rd, .vec_data, .stack_bus, .stack_rdata);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	function automatic logic [12:0] vval(logic [12:0] v);
		return {v[3:0], 9'h0a5};
	endfunction
	function automatic logic [4:0] alu_flags(alu_op_t op, logic [7:0] x, logic [7:0] y,
		logic [4:0] f);
		logic [8:0] s;
		logic cin;
		cin = (op == op_adc) ? f[ccr_c] : 1'b0;
		s = (op == op_sub) ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y} + cin;
		if (op != op_sub) begin
			f[ccr_h] = ({1'b0, x[3:0]} + {1'b0, y[3:0]} + cin) > 5'h0f;
		end
		f[ccr_n] = s[7];
		f[ccr_z] = (s[7:0] == 8'h00);
		f[ccr_c] = s[8];
		return f;
	endfunction
	task automatic settle();
		int n;
		n = 0;
		while (exec_stall !== 1'b0 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		chk(n < 40, 1'b1);
	endtask
	task automatic issue(seq_cmd_t c, alu_op_t op, logic [7:0] x, logic [7:0] y,
		logic bv = 1'b0);
		settle();
		exec = '{1'b1, c, op, x, y, np, bv};
		@(negedge mclk);
		exec.done = 1'b0;
		// one idle edge so back-to-back calls never redrive done in one step
		@(negedge mclk);
	endtask
	task automatic pulse(logic via_port);
		if (via_port) begin
			portb_pins_n[2] = 1'b0;
		end else begin
			ext_irq_n = 1'b0;
		end
		repeat (4) @(negedge mclk);
		portb_pins_n = 8'hff;
		ext_irq_n = 1'b1;
	endtask
	task automatic check_entry(logic [12:0] v);
		settle();
		for (int i = 0; i < 5; i++) begin
			chk(mdl.push_addr[i], {2'b11, esp - 6'(i)});
		end
		chk(mdl.push_log[0], np[7:0]);
		chk(mdl.push_log[1], {3'h0, np[12:8]});
		chk(mdl.push_log[2], ex);
		chk(mdl.push_log[3], ea);
		chk(mdl.push_log[4], {3'h7, eccr});
		{sa, sx, ssp, sccr, snp} = {ea, ex, esp, eccr, np};
		esp = esp - 6'h05;
		eccr[ccr_i] = 1'b1;
		chk(stack_pointer, esp);
		chk(condition_flags, eccr);
		chk(program_counter, vval(v));
		mdl.push_log.delete();
		mdl.push_addr.delete();
	endtask
	task automatic rti_chk();
		issue(cmd_none, op_load_a, 8'h00, 8'h99);
		issue(cmd_rti, op_none, 8'h00, 8'h00);
		settle();
		{ea, ex, esp, eccr} = {sa, sx, ssp, sccr};
		chk(program_counter, snp);
		chk({accum, index_reg}, {ea, ex});
		chk({stack_pointer, condition_flags}, {esp, eccr});
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		exec = '0;
		{ext_irq_n, portb_pins_n, portb_irq_en} = {1'b1, 8'hff, 8'h04};
		{src_en, src_flag, np} = {11'h7ff, 11'h000, 13'h0000};
		void'($urandom(42));
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		chk(program_counter, vval(pc_rst_vec));
		chk({stack_pointer, condition_flags}, {sp_top, ccr_rst});
		eccr = ccr_rst;
		esp = sp_top;
		$display("test reset done");
		for (int i = 0; i < 30; i++) begin
			o = (i % 3 == 0) ? op_add : (i % 3 == 1) ? op_adc : op_sub;
			a = (i < 3) ? ca[i] : (i == 29) ? 8'h40 : 8'($urandom);
			b = (i < 3 || i == 29) ? 8'h01 : 8'($urandom);
			issue(cmd_none, o, a, b);
			eccr = alu_flags(o, a, b, eccr);
			chk(condition_flags, eccr);
		end
		issue(cmd_none, op_logic, 8'h00, 8'h80);
		eccr[ccr_n] = 1'b1;
		eccr[ccr_z] = 1'b0;
		chk({accum, condition_flags}, {8'h80, eccr});
		issue(cmd_none, op_setc, 8'h00, 8'h00, 1'b1);
		eccr[ccr_c] = 1'b1;
		chk(condition_flags, eccr);
		issue(cmd_none, op_shift, 8'h00, 8'h00, 1'b0);
		eccr[ccr_c] = 1'b0;
		eccr[ccr_n] = 1'b0;
		eccr[ccr_z] = 1'b1;
		chk({accum, condition_flags}, {8'h00, eccr});
		// loaded value rides on the second operand; positive nonzero clears n and z
		ea = 8'h01 + 8'($urandom % 127);
		ex = 8'h01 + 8'($urandom % 127);
		issue(cmd_none, op_load_a, 8'h00, ea);
		issue(cmd_none, op_load_x, 8'h00, ex);
		eccr[ccr_z] = 1'b0;
		chk({accum, index_reg}, {ea, ex});
		chk(condition_flags, eccr);
		$display("test alu flags done");
		for (int k = 0; k < 5; k++) begin
			np = 13'($urandom);
			case (k)
				0: begin
					src_flag.tmr = 3'h1 << ($urandom % 3);
					issue(cmd_none, op_none, 8'h00, 8'h00);
					chk({exec_stall, 8'(mdl.push_log.size())}, 9'h000);
					issue(cmd_none, op_cli, 8'h00, 8'h00);
					eccr[ccr_i] = 1'b0;
					chk(condition_flags, eccr);
				end
				1: src_flag.async_ser = 5'h01 << ($urandom % 5);
				2: src_flag.sync_ser = 2'h1 << ($urandom % 2);
				3: begin
					src_flag.tmr = 3'h4;
					pulse(1'b0);
				end
				default: begin
					src_flag.sync_ser = 2'h2;
					pulse(1'b1);
				end
			endcase
			repeat (2) @(negedge mclk);
			if (exec_stall === 1'b0) begin
				issue(cmd_none, op_none, 8'h00, 8'h00);
			end
			check_entry(k == 0 ? tmr_vec : k == 1 ? async_vec : k == 2 ? sync_vec : ext_vec);
			src_flag = '0;
			rti_chk();
			$display("test source %0d done", k);
		end
		issue(cmd_none, op_sei, 8'h00, 8'h00);
		eccr[ccr_i] = 1'b1;
		// thirteen entries push 65 bytes, one more than the page holds
		for (int i = 0; i < 13; i++) begin
			np = 13'($urandom);
			issue(cmd_swi, op_none, 8'h00, 8'h00);
			check_entry(swi_vec);
		end
		issue(cmd_rsp, op_none, 8'h00, 8'h00);
		settle();
		esp = sp_top;
		chk(stack_pointer, esp);
		// a call takes two bytes, its return gives them back
		issue(cmd_push, op_none, 8'h00, 8'h00);
		issue(cmd_push, op_none, 8'h00, 8'h00);
		chk(stack_pointer, esp - 6'h02);
		issue(cmd_pull, op_none, 8'h00, 8'h00);
		issue(cmd_pull, op_none, 8'h00, 8'h00);
		chk(stack_pointer, esp);
		$display("test trap and wrap done");
		np = 13'($urandom);
		issue(cmd_wait, op_none, 8'h00, 8'h00);
		repeat (3) @(negedge mclk);
		chk({osc_off, cpu_clk_off}, 2'b01);
		src_flag.async_ser = 5'h10;
		eccr[ccr_i] = 1'b0;
		check_entry(async_vec);
		src_flag = '0;
		np = 13'($urandom);
		issue(cmd_stop, op_none, 8'h00, 8'h00);
		src_flag.tmr = 3'h2;
		repeat (8) @(negedge mclk);
		chk({osc_off, cpu_clk_off}, 2'b11);
		src_flag = '0;
		pulse(1'b0);
		// leaving stop clears the mask before the flags are stacked
		eccr[ccr_i] = 1'b0;
		check_entry(ext_vec);
		chk(cpu_clk_off, 1'b0);
		$display("test low power done");
		final_report();
	end
	// about thirty times the cycles the sequence needs
	initial begin
		#250000;
		bad_count++;
		final_report();
	end
endmodule

// [verif/mem_model.sv]
// stack memory and vector table model beside the sequencer
`timescale 1ns/100ps
module mem_model
	import cpu_seq_pkg::*;
(
	// clock
	input wire logic mclk,
	// vector table
	input wire logic [12:0] vec_addr,
	input wire logic vec_rd,
	output logic [12:0] vec_data,
	// stack memory
	input cpu_seq_pkg::stack_bus_t stack_bus,
	output logic [7:0] stack_rdata
);
	logic [7:0] mem [256];
	logic [7:0] last_q = 8'h5a;
	logic [7:0] push_log [$];
	logic [7:0] push_addr [$];
	// off-cycle values inverted so a stale read never passes for a fresh one
	assign vec_data = vec_rd ? {vec_addr[3:0], 9'h0a5} : ~{vec_addr[3:0], 9'h0a5};
	assign stack_rdata = stack_bus.re ? mem[stack_bus.addr] : ~last_q;
	always @(posedge mclk) begin
		if (stack_bus.re) begin
			last_q <= mem[stack_bus.addr];
		end
		if (stack_bus.we) begin
			mem[stack_bus.addr] <= stack_bus.wdata;
			push_log.push_back(stack_bus.wdata);
			push_addr.push_back(stack_bus.addr);
		end
	end
endmodule
